// *** rtl/sac_pkg.sv ***
package sac_pkg;
    // Byte addresses on the register bus
    localparam logic [15:0] ADR_CFG    = 16'h7040; // serial_config_control
    localparam logic [15:0] ADR_OPCTL  = 16'h7044; // operation_control_reg
    localparam logic [15:0] ADR_STATUS = 16'h7048; // status_reg
    localparam logic [15:0] ADR_TXDATA = 16'h704C;
    localparam logic [15:0] ADR_RXBUF  = 16'h7050; // receive_buffer
    localparam logic [15:0] ADR_PRI    = 16'h7054; // priority_control_reg
    localparam logic [15:0] ADR_BAUD   = 16'h7058;

    // serial_config_control fields
    localparam int CFG_SRST_N  = 7;
    localparam int CFG_CPOL    = 6;
    localparam int CFG_LBK     = 4;
    localparam int CFG_LEN_MSB = 3;
    localparam logic [7:0] CFG_WMASK = 8'hDF;
    localparam logic [7:0] CFG_RST   = 8'h00;

    // operation_control_reg fields
    localparam int OPC_PHA    = 3;
    localparam int OPC_MASTER = 2;
    localparam int OPC_TALK   = 1;
    localparam logic [7:0] OPC_WMASK = 8'h0E;
    localparam logic [7:0] OPC_RST   = 8'h00;

    // status_reg fields
    localparam int STS_OVR   = 7;
    localparam int STS_INT   = 6;
    localparam int STS_TXF   = 5;
    localparam int STS_LEFT  = 4;
    localparam int STS_BUSY  = 0;

    // priority_control_reg fields
    localparam int PRI_INV   = 1;
    localparam int PRI_3WIRE = 0;
    localparam logic [7:0] PRI_WMASK = 8'h03;
    localparam logic [7:0] PRI_RST   = 8'h00;

    // Half shift-clock period is BAUD+1 system clocks
    localparam logic [7:0] BAUD_RST = 8'h03;
endpackage

// *** rtl/sac_sync.sv ***
`timescale 1ns/1ps
module sac_sync #(
    parameter int         W       = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input  wire logic         clk_i, // System clock
    input  wire logic         rst_i, // Synchronous reset
    input  wire logic         ce_i,  // Clock enable
    input  wire logic [W-1:0] d_i,   // Asynchronous inputs
    output logic      [W-1:0] q_o    // Synchronised outputs
);
    logic [W-1:0] s1_q;

    for (genvar i = 0; i < W; i++) begin : g_bit
        always_ff @(posedge clk_i) begin
            if (rst_i) begin
                s1_q[i] <= RST_VAL[i];
                q_o[i]  <= RST_VAL[i];
            end else if (ce_i) begin
                s1_q[i] <= d_i[i];
                q_o[i]  <= s1_q[i];
            end
        end
    end
endmodule

// *** rtl/sac_core.sv ***
`timescale 1ns/1ps
// How it works
// - Normal-select module of a pair captures right channel
// - Inverted-select module captures left channel
// - Soft reset low clears overrun, complete, txfull
// - Soft reset leaves configuration untouched
// - Master soft reset returns shift clock idle
// - Character written during reset is never sent
// - Polarity 0: shift clock idles low
// - Pol0 pha0: drive rising, sample falling
// - Pol0 pha1: early first bit, sample rising
// - Polarity 1: shift clock idles high
// - Pol1 pha0: drive falling, sample rising
// - Pol1 pha1: early first bit, sample falling
// - Config bit 5 reads zero, ignores writes
// - Loopback only acts in master mode
// - Loopback ties output to input, off after reset
// - Character length is field plus one
// - Talk low floats data output, receive continues
module sac_core (
    input  wire logic        clk_i,      // System clock, 100 MHz
    input  wire logic        rst_i,      // Synchronous reset, active high
    input  wire logic        ce_i,       // Clock enable, freezes all state when low
    input  wire logic        wb_cyc_i,   // Wishbone cycle
    input  wire logic        wb_stb_i,   // Wishbone strobe
    input  wire logic        wb_we_i,    // Wishbone write enable
    input  wire logic [15:0] wb_adr_i,   // Wishbone byte address
    input  wire logic [31:0] wb_dat_i,   // Wishbone write data
    input  wire logic [3:0]  wb_sel_i,   // Wishbone byte selects
    output logic      [31:0] wb_dat_o,   // Wishbone read data
    output logic             wb_ack_o,   // Wishbone acknowledge
    input  wire logic        sclk_i,     // shift_clock pin in
    output logic             sclk_o,     // shift_clock pin out
    output logic             sclk_oe_o,  // shift_clock drive enable
    input  wire logic        ste_n_i,    // slave_select_pin in
    output logic             ste_n_o,    // slave_select_pin out
    output logic             ste_oe_o,   // slave_select_pin drive enable
    input  wire logic        mosi_i,     // Master-out pin in
    output logic             mosi_o,     // Master-out pin out
    output logic             mosi_oe_o,  // Master-out drive enable
    input  wire logic        miso_i,     // Master-in pin in
    output logic             miso_o,     // Master-in pin out
    output logic             miso_oe_o   // Master-in drive enable
);
    typedef enum logic [1:0] {SAC_IDLE, SAC_RUN, SAC_DONE} sac_state_t;

    // Registers
    logic [7:0]  cfg_q, cfg_d, opc_q, opc_d, pri_q, pri_d, baud_q, baud_d;
    logic [15:0] txbuf_q, txbuf_d, rxbuf_q, rxbuf_d;
    logic        ovr_q, ovr_d, int_q, int_d, txf_q, txf_d, left_q, left_d;
    logic [31:0] rdat_d;
    logic        ack_d;
    // Engine
    sac_state_t  st_q, st_d;
    logic [15:0] txsh_q, txsh_d, rxsh_q, rxsh_d;
    logic [7:0]  hc_q, hc_d;
    logic [4:0]  edge_q, edge_d;
    logic [4:0]  bits_q, bits_d;
    logic        lvl_q, lvl_d, out_q, out_d, selp_q, selp_d, sclkp_q, sclkp_d;
    logic        sclk_d, sclk_oe_d, ste_d, ste_oe_d;
    logic        mosi_d, mosi_oe_d, miso_d, miso_oe_d;
    // Synchronised pins
    logic        sclk_s, ste_s, mosi_s, miso_s;

    sac_sync #(.W(4), .RST_VAL(4'h4)) u_sync (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .ce_i  (ce_i),
        .d_i   ({sclk_i, ste_n_i, mosi_i, miso_i}),
        .q_o   ({sclk_s, ste_s, mosi_s, miso_s})
    );

    logic       srst_n, cpol, pha, master, talk, lbk, tri3, inv;
    logic [3:0] len_m1;
    assign srst_n = cfg_q[sac_pkg::CFG_SRST_N];
    assign cpol   = cfg_q[sac_pkg::CFG_CPOL];
    assign lbk    = cfg_q[sac_pkg::CFG_LBK];
    assign len_m1 = cfg_q[sac_pkg::CFG_LEN_MSB:0];
    assign pha    = opc_q[sac_pkg::OPC_PHA];
    assign master = opc_q[sac_pkg::OPC_MASTER];
    assign talk   = opc_q[sac_pkg::OPC_TALK];
    assign tri3   = pri_q[sac_pkg::PRI_3WIRE];
    assign inv    = pri_q[sac_pkg::PRI_INV];

    logic req, wr, rd;
    assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign wr  = req & wb_we_i;
    assign rd  = req & ~wb_we_i;

    // Register file and flags
    logic done_ev, ld_ev;
    logic [15:0] rx_done;
    always_comb begin
        cfg_d   = cfg_q;
        opc_d   = opc_q;
        pri_d   = pri_q;
        baud_d  = baud_q;
        txbuf_d = txbuf_q;
        rxbuf_d = rxbuf_q;
        ovr_d   = ovr_q;
        int_d   = int_q;
        txf_d   = txf_q;
        left_d  = left_q;
        rdat_d  = 32'h0000_0000;
        ack_d   = req;
        if (wr && wb_sel_i[0]) begin
            unique case (wb_adr_i)
                sac_pkg::ADR_CFG:    cfg_d  = wb_dat_i[7:0] & sac_pkg::CFG_WMASK;
                sac_pkg::ADR_OPCTL:  opc_d  = wb_dat_i[7:0] & sac_pkg::OPC_WMASK;
                sac_pkg::ADR_PRI:    pri_d  = wb_dat_i[7:0] & sac_pkg::PRI_WMASK;
                sac_pkg::ADR_BAUD:   baud_d = wb_dat_i[7:0];
                sac_pkg::ADR_STATUS: if (wb_dat_i[sac_pkg::STS_OVR]) ovr_d = 1'b0;
                sac_pkg::ADR_TXDATA: if (srst_n) begin
                    // Writes while in soft reset are dropped
                    txbuf_d = {wb_sel_i[1] ? wb_dat_i[15:8] : txbuf_q[15:8], wb_dat_i[7:0]};
                    txf_d   = 1'b1;
                end
                default: ;
            endcase
        end
        if (rd) begin
            unique case (wb_adr_i)
                sac_pkg::ADR_CFG:    rdat_d[7:0] = cfg_q;
                sac_pkg::ADR_OPCTL:  rdat_d[7:0] = opc_q;
                sac_pkg::ADR_PRI:    rdat_d[7:0] = pri_q;
                sac_pkg::ADR_BAUD:   rdat_d[7:0] = baud_q;
                sac_pkg::ADR_TXDATA: rdat_d[15:0] = txbuf_q;
                sac_pkg::ADR_STATUS: begin
                    rdat_d[sac_pkg::STS_OVR]  = ovr_q;
                    rdat_d[sac_pkg::STS_INT]  = int_q;
                    rdat_d[sac_pkg::STS_TXF]  = txf_q;
                    rdat_d[sac_pkg::STS_LEFT] = left_q;
                    rdat_d[sac_pkg::STS_BUSY] = (st_q != SAC_IDLE);
                end
                sac_pkg::ADR_RXBUF: begin
                    rdat_d[15:0] = rxbuf_q;
                    int_d        = 1'b0;
                end
                default: ;
            endcase
        end
        if (ld_ev) begin
            txf_d = 1'b0;
        end
        if (done_ev) begin
            rxbuf_d = rx_done;
            if (int_q && int_d == int_q) begin
                ovr_d = 1'b1;
            end
            int_d  = 1'b1;
            left_d = inv;
        end
        if (!srst_n) begin
            ovr_d = 1'b0;
            int_d = 1'b0;
            txf_d = 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cfg_q    <= sac_pkg::CFG_RST;
            opc_q    <= sac_pkg::OPC_RST;
            pri_q    <= sac_pkg::PRI_RST;
            baud_q   <= sac_pkg::BAUD_RST;
            txbuf_q  <= 16'h0000;
            rxbuf_q  <= 16'h0000;
            ovr_q    <= 1'b0;
            int_q    <= 1'b0;
            txf_q    <= 1'b0;
            left_q   <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
            wb_ack_o <= 1'b0;
        end else if (ce_i) begin
            cfg_q    <= cfg_d;
            opc_q    <= opc_d;
            pri_q    <= pri_d;
            baud_q   <= baud_d;
            txbuf_q  <= txbuf_d;
            rxbuf_q  <= rxbuf_d;
            ovr_q    <= ovr_d;
            int_q    <= int_d;
            txf_q    <= txf_d;
            left_q   <= left_d;
            wb_dat_o <= rdat_d;
            wb_ack_o <= ack_d;
        end
    end

    // Shift engine
    logic sel_act, in_bit, lead, trail, drv, smp, last;
    logic [15:0] ld_word;
    always_comb begin
        st_d    = st_q;
        hc_d    = hc_q;
        edge_d  = edge_q;
        bits_d  = bits_q;
        lvl_d   = lvl_q;
        txsh_d  = txsh_q;
        rxsh_d  = rxsh_q;
        out_d   = out_q;
        done_ev = 1'b0;
        ld_ev   = 1'b0;
        lead    = 1'b0;
        trail   = 1'b0;
        ld_word = txsh_q;
        sel_act = (ste_s ^ inv) == 1'b0;
        selp_d  = sel_act;
        sclkp_d = sclk_s;
        // Own output returns as input in loopback or in three-wire talk
        if (master && lbk) begin
            in_bit = out_q;
        end else if (tri3 && talk) begin
            in_bit = out_q;
        end else if (tri3) begin
            in_bit = master ? mosi_s : miso_s;
        end else begin
            in_bit = master ? miso_s : mosi_s;
        end
        if (master) begin
            unique case (st_q)
                SAC_IDLE: begin
                    lvl_d  = cpol;
                    edge_d = 5'h00;
                    if (txf_q) begin
                        st_d    = SAC_RUN;
                        ld_ev   = 1'b1;
                        ld_word = txbuf_q;
                        hc_d    = baud_q;
                    end
                end
                SAC_RUN: begin
                    if (hc_q == 8'h00) begin
                        hc_d   = baud_q;
                        lvl_d  = ~lvl_q;
                        lead   = ~edge_q[0];
                        trail  = edge_q[0];
                        edge_d = edge_q + 5'h01;
                    end else begin
                        hc_d = hc_q - 8'h01;
                    end
                end
                SAC_DONE: begin
                    // Hold idle for one half period between characters
                    if (hc_q == 8'h00) begin
                        st_d = SAC_IDLE;
                    end else begin
                        hc_d = hc_q - 8'h01;
                    end
                end
                default: st_d = SAC_IDLE;
            endcase
            last = trail && (edge_q == {len_m1, 1'b1});
        end else begin
            st_d  = sel_act ? SAC_RUN : SAC_IDLE;
            lvl_d = cpol;
            lead  = sel_act && (sclk_s != sclkp_q) && (sclk_s != cpol);
            trail = sel_act && (sclk_s != sclkp_q) && (sclk_s == cpol);
            if (sel_act && !selp_q) begin
                bits_d = 5'h00;
                ld_ev  = txf_q;
                if (txf_q) begin
                    ld_word = txbuf_q;
                end
            end
            last = 1'b0;
        end
        drv = pha ? (trail && !last) : lead;
        smp = pha ? lead : trail;
        if (ld_ev && pha) begin
            out_d  = ld_word[len_m1];
            txsh_d = ld_word << 1;
        end else if (drv) begin
            out_d  = ld_word[len_m1];
            txsh_d = ld_word << 1;
        end else begin
            txsh_d = ld_word;
        end
        if (smp) begin
            rxsh_d = {rxsh_q[14:0], in_bit};
            bits_d = bits_q + 5'h01;
        end
        rx_done = rxsh_d;
        if (smp && bits_q == {1'b0, len_m1}) begin
            done_ev = 1'b1;
            bits_d  = 5'h00;
            rxsh_d  = 16'h0000;
            if (!master && txf_q) begin
                ld_ev  = 1'b1;
                txsh_d = txbuf_q;
                if (pha) begin
                    out_d  = txbuf_q[len_m1];
                    txsh_d = txbuf_q << 1;
                end
            end
        end
        if (master && last) begin
            st_d = SAC_DONE;
        end
        if (!srst_n) begin
            st_d   = SAC_IDLE;
            lvl_d  = cpol;
            bits_d = 5'h00;
            rxsh_d = 16'h0000;
            ld_ev  = 1'b0;
            done_ev = 1'b0;
        end
        // Pin drive values, registered below
        sclk_d    = master ? lvl_q : 1'b0;
        sclk_oe_d = master;
        ste_d     = ~(master && st_q == SAC_RUN);
        ste_oe_d  = master;
        mosi_d    = out_q;
        miso_d    = out_q;
        mosi_oe_d = master && talk;
        miso_oe_d = !master && talk && sel_act;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_q      <= SAC_IDLE;
            hc_q      <= 8'h00;
            edge_q    <= 5'h00;
            bits_q    <= 5'h00;
            lvl_q     <= 1'b0;
            txsh_q    <= 16'h0000;
            rxsh_q    <= 16'h0000;
            out_q     <= 1'b0;
            selp_q    <= 1'b0;
            sclkp_q   <= 1'b0;
            sclk_o    <= 1'b0;
            sclk_oe_o <= 1'b0;
            ste_n_o   <= 1'b1;
            ste_oe_o  <= 1'b0;
            mosi_o    <= 1'b0;
            mosi_oe_o <= 1'b0;
            miso_o    <= 1'b0;
            miso_oe_o <= 1'b0;
        end else if (ce_i) begin
            st_q      <= st_d;
            hc_q      <= hc_d;
            edge_q    <= edge_d;
            bits_q    <= bits_d;
            lvl_q     <= lvl_d;
            txsh_q    <= txsh_d;
            rxsh_q    <= rxsh_d;
            out_q     <= out_d;
            selp_q    <= selp_d;
            sclkp_q   <= sclkp_d;
            sclk_o    <= sclk_d;
            sclk_oe_o <= sclk_oe_d;
            ste_n_o   <= ste_d;
            ste_oe_o  <= ste_oe_d;
            mosi_o    <= mosi_d;
            mosi_oe_o <= mosi_oe_d;
            miso_o    <= miso_d;
            miso_oe_o <= miso_oe_d;
        end
    end
endmodule

// *** bench/sac_core_chk.sv ***
`timescale 1ns/1ps
module sac_core_chk (
    input wire logic clk_i,     // System clock
    input wire logic rst_i,     // Synchronous reset
    input wire logic wb_cyc_i,  // Bus cycle
    input wire logic wb_stb_i,  // Bus strobe
    input wire logic wb_ack_o,  // Bus acknowledge
    input wire logic sclk_o,    // Shift clock out
    input wire logic sclk_oe_o, // Shift clock enable
    input wire logic ste_n_o,   // Select out
    input wire logic ste_oe_o,  // Select enable
    input wire logic mosi_oe_o, // Master-out enable
    input wire logic miso_oe_o  // Master-in enable
);
    logic       lvl_q;
    logic [5:0] cnt_q;

    // Idle level before a frame and clock edges inside it
    always_ff @(posedge clk_i) begin
        if (ste_n_o) begin
            lvl_q <= sclk_o;
        end
        if (rst_i || ste_n_o) begin
            cnt_q <= 6'h00;
        end else if (cnt_q < 6'h3F) begin
            cnt_q <= cnt_q + 6'(sclk_o ^ $past(sclk_o));
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
    a_ack_after_req: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("request not answered in one cycle");
    a_ack_has_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without request");
    a_pins_after_reset: assert property ($fell(rst_i) |->
        ste_n_o && !sclk_oe_o && !mosi_oe_o && !miso_oe_o)
        else $error("pins not released after reset");
    a_sclk_idle_stable: assert property (sclk_oe_o && ste_n_o && $past(ste_n_o)
        && $past(ste_n_o, 2) && !$past(wb_ack_o) && !$past(wb_ack_o, 2)
        && !$past(wb_ack_o, 3) |-> $stable(sclk_o))
        else $error("shift clock moved outside a frame");
    a_frame_idle_match: assert property ($rose(ste_n_o) |-> sclk_o == lvl_q)
        else $error("shift clock not idle at frame end");
    a_edge_limit: assert property (!ste_n_o |-> cnt_q <= 6'h20)
        else $error("more than sixteen bits in a frame");
    a_miso_slave: assert property (miso_oe_o |-> !sclk_oe_o)
        else $error("master-in driven in master mode");
    a_ste_master: assert property (!ste_n_o |-> ste_oe_o && sclk_oe_o)
        else $error("select driven low outside master mode");
endmodule

bind sac_core sac_core_chk u_chk (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_ack_o(wb_ack_o), .sclk_o(sclk_o), .sclk_oe_o(sclk_oe_o),
    .ste_n_o(ste_n_o), .ste_oe_o(ste_oe_o), .mosi_oe_o(mosi_oe_o),
    .miso_oe_o(miso_oe_o)
);

// *** bench/sac_partner.sv ***
`timescale 1ns/1ps
module sac_partner (
    input  wire logic mosi_i,  // Master-out wire
    output logic      sclk_o,  // Shift clock to the device
    output logic      ste_n_o, // Select to the device
    output logic      mosi_o,  // Data to the device
    output logic      miso_o   // Data back to the device
);
    // A slave that answers the inverse of what it hears
    assign miso_o = ~mosi_i;

    initial begin
        sclk_o = 1'b0;
        ste_n_o = 1'b1;
        mosi_o = 1'b0;
    end

    // Sixteen bits, clock idles low, bit set up before each rising edge
    task automatic send(input logic [15:0] d, input logic act);
        int k;
        ste_n_o = ~act;
        #125;
        ste_n_o = act;
        for (k = 15; k >= 0; k--) begin
            mosi_o = d[k];
            #62.5;
            sclk_o = 1'b1;
            #62.5;
            sclk_o = 1'b0;
        end
        #62.5;
        ste_n_o = ~act;
        mosi_o = ~mosi_o;
    endtask
endmodule

// *** bench/sac_core_bench.sv ***
`timescale 1ns/1ps
module sac_core_bench;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        cyc = 1'b0;
    logic        stb = 1'b0;
    logic        we = 1'b0;
    logic [15:0] adr = '0;
    logic [31:0] wdat = '0;
    logic [31:0] rdat;
    logic [31:0] dat_o;
    logic        ack, sclk_o, sclk_oe, ste_n_o, ste_oe, mosi_o, mosi_oe, miso_o, miso_oe;
    logic        p_sclk, p_ste_n, p_mosi, p_miso;
    int          miscompares = 0;
    int          cmp_count = 0;
    int          i;
    logic [31:0] lenv [3] = '{32'h00, 32'h07, 32'h0F};
    wire logic   w_sclk = sclk_oe ? sclk_o : p_sclk;
    wire logic   w_ste_n = ste_oe ? ste_n_o : p_ste_n;
    wire logic   w_mosi = mosi_oe ? mosi_o : p_mosi;
    wire logic   w_miso = miso_oe ? miso_o : p_miso;

    sac_core u_sac_core (
        .clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(4'hF),
        .wb_dat_o(dat_o), .wb_ack_o(ack), .sclk_i(w_sclk), .sclk_o(sclk_o),
        .sclk_oe_o(sclk_oe), .ste_n_i(w_ste_n), .ste_n_o(ste_n_o), .ste_oe_o(ste_oe),
        .mosi_i(w_mosi), .mosi_o(mosi_o), .mosi_oe_o(mosi_oe), .miso_i(w_miso),
        .miso_o(miso_o), .miso_oe_o(miso_oe)
    );
    sac_partner u_sac_partner (
        .mosi_i(w_mosi), .sclk_o(p_sclk), .ste_n_o(p_ste_n), .mosi_o(p_mosi),
        .miso_o(p_miso)
    );

    initial begin
        forever #5 clk_i = ~clk_i;
    end

    task automatic final_report;
        if (miscompares == 0 && cmp_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic wb(input logic w, input logic [15:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        // Look at ack and data mid-cycle, where they have settled
        do begin
            @(negedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 50);
        rdat = dat_o;
        @(posedge clk_i);
        if (n >= 50) miscompares++;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic rd(input logic [15:0] a, input logic [31:0] exp);
        wb(1'b0, a, '0);
        chk(rdat, exp);
    endtask

    // Poll status until the given flag is up
    task automatic waitf(input int b);
        int n;
        n = 0;
        rdat = '0;
        while (rdat[b] !== 1'b1 && n < 400) begin
            wb(1'b0, sac_pkg::ADR_STATUS, '0);
            n++;
        end
        if (n >= 400) miscompares++;
    endtask

    initial begin
        #400000;
        miscompares++;
        final_report();
    end

    initial begin
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(sac_pkg::ADR_CFG, 32'h00);
        rd(sac_pkg::ADR_OPCTL, 32'h00);
        rd(sac_pkg::ADR_PRI, 32'h00);
        rd(sac_pkg::ADR_BAUD, 32'h03);
        wb(1'b1, sac_pkg::ADR_CFG, 32'hFF);
        wb(1'b1, sac_pkg::ADR_OPCTL, 32'h06);
        rd(sac_pkg::ADR_CFG, 32'hDF);
        chk(32'(w_sclk), 32'h1);
        wb(1'b1, sac_pkg::ADR_TXDATA, 32'h1234);
        waitf(6);
        wb(1'b1, sac_pkg::ADR_TXDATA, 32'h4321);
        waitf(7);
        chk(rdat & 32'hE0, 32'hC0);
        wb(1'b1, sac_pkg::ADR_CFG, 32'h5F);
        wb(1'b0, sac_pkg::ADR_STATUS, '0);
        chk(rdat & 32'hE0, 32'h00);
        rd(sac_pkg::ADR_CFG, 32'h5F);
        chk(32'(w_sclk), 32'h1);
        wb(1'b1, sac_pkg::ADR_TXDATA, 32'hFFFF);
        wb(1'b1, sac_pkg::ADR_CFG, 32'hDF);
        wb(1'b0, sac_pkg::ADR_STATUS, '0);
        chk(rdat & 32'h21, 32'h00);
        for (i = 0; i < 3; i++) begin
            wb(1'b1, sac_pkg::ADR_CFG, 32'h10 | lenv[i]);
            wb(1'b1, sac_pkg::ADR_OPCTL, i[0] ? 32'h0E : 32'h06);
            wb(1'b1, sac_pkg::ADR_CFG, 32'h90 | lenv[i]);
            wb(1'b1, sac_pkg::ADR_TXDATA, 32'hB6D9);
            waitf(6);
            rd(sac_pkg::ADR_RXBUF, 32'hB6D9 & ((32'h2 << lenv[i]) - 32'h1));
            chk(32'(w_sclk), 32'h0);
        end
        wb(1'b1, sac_pkg::ADR_CFG, 32'h47);
        wb(1'b1, sac_pkg::ADR_OPCTL, 32'h06);
        wb(1'b1, sac_pkg::ADR_CFG, 32'hC7);
        wb(1'b1, sac_pkg::ADR_TXDATA, 32'hD9);
        waitf(6);
        rd(sac_pkg::ADR_RXBUF, 32'h26);
        wb(1'b1, sac_pkg::ADR_CFG, 32'h47);
        wb(1'b1, sac_pkg::ADR_OPCTL, 32'h0E);
        wb(1'b1, sac_pkg::ADR_CFG, 32'hC7);
        wb(1'b1, sac_pkg::ADR_TXDATA, 32'hD9);
        waitf(6);
        rd(sac_pkg::ADR_RXBUF, 32'h26);
        chk(32'(w_sclk), 32'h1);
        wb(1'b1, sac_pkg::ADR_CFG, 32'h1F);
        wb(1'b1, sac_pkg::ADR_OPCTL, 32'h08);
        wb(1'b1, sac_pkg::ADR_CFG, 32'h9F);
        for (i = 0; i < 2; i++) begin
            wb(1'b1, sac_pkg::ADR_PRI, 32'(i) << 1);
            u_sac_partner.send(i[0] ? 16'h5A3C : 16'hA5C3, i[0]);
            waitf(6);
            chk(rdat & 32'h10, 32'(i) << 4);
            rd(sac_pkg::ADR_RXBUF, i[0] ? 32'h5A3C : 32'hA5C3);
            chk(32'(miso_oe), 32'h0);
        end
        final_report();
    end
endmodule
